// *** asc_sequencer_control.sv ***
/*
  asc_sequencer_control: converter sequencer for eight multiplexed inputs,
  with mode register, result register and completion request.
  Assumes an analog mux, trial DAC and comparator outside, driven from the
  outputs here; the trigger pin is asynchronous, the mode write is not.
*/
`timescale 1ns/1ns
module asc_sequencer_control
  import asc_pkg::*;
(
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  input  wire logic              enable_i,
  // converter mode register write port
  input  wire logic              mode_wr_i,
  input  wire logic [MODE_W-1:0] mode_wdata_i,
  // trigger pin
  input  wire logic              external_trigger_irq_i,
  // analog front end
  input  wire logic              comparator_i,
  output logic [CH_W-1:0]        analog_input_n_sel_o,
  output logic                   sample_hold_o,
  output logic [RES_W-1:0]       dac_code_o,
  // status and results
  output logic [MODE_W-1:0]      converter_mode_reg_o,
  output logic [RES_W-1:0]       conversion_result_reg_o,
  output logic [CH_W-1:0]        result_channel_o,
  output logic                   busy_o,
  output logic                   conversion_done_irq_o
);

  asc_state_e        state_q, state_d;
  logic [MODE_W-1:0] mode_q, mode_d;
  logic [CH_W-1:0]   ch_q, ch_d;
  logic [CH_W-1:0]   res_ch_q, res_ch_d;
  logic [RES_W-1:0]  result_q, result_d;
  logic              start_q, start_d;
  logic              abort_q, abort_d;
  logic              irq_q, irq_d;
  logic              trig_edge;
  logic              sar_busy, sar_done;
  logic [RES_W-1:0]  sar_result;
  logic              hw_q, sel_q;
  logic [CH_W-1:0]   last_ch;

  ////////////////////////////////////////////////////////////////////////////
  // trigger pin and step engine
  asc_edge_sync u_trig (
    .clock_i  (clock_i),
    .reset_i  (reset_i),
    .enable_i (enable_i),
    .pin_i    (external_trigger_irq_i),
    .edge_o   (trig_edge)
  );

  asc_sar_core #(
    .W        (RES_W),
    .STEP_CYC (STEP_CYCLES)
  ) u_sar (
    .clock_i      (clock_i),
    .reset_i      (reset_i),
    .enable_i     (enable_i),
    .start_i      (start_q),
    .abort_i      (abort_q),
    .comparator_i (comparator_i),
    .sample_o     (sample_hold_o),
    .busy_o       (sar_busy),
    .done_o       (sar_done),
    .trial_o      (dac_code_o),
    .result_o     (sar_result)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode field decode
  assign hw_q    = mode_q[MODE_HW_BIT];
  assign sel_q   = mode_q[MODE_SEL_BIT];
  assign last_ch = mode_channel(mode_q);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_d  = state_q;
    mode_d   = mode_q;
    ch_d     = ch_q;
    res_ch_d = res_ch_q;
    result_d = result_q;
    start_d  = 1'b0;
    abort_d  = 1'b0;
    irq_d    = 1'b0;
    if (mode_wr_i) begin
      // any write restarts from a clean step engine
      mode_d  = mode_wdata_i;
      abort_d = 1'b1;
      ch_d    = first_channel(mode_wdata_i);
      if (!mode_wdata_i[MODE_RUN_BIT])
        state_d = ASC_STOPPED;
      else if (mode_wdata_i[MODE_HW_BIT])
        state_d = ASC_ARMED;
      else
        state_d = ASC_RUNNING;
    end else begin
      unique case (state_q)
        ASC_STOPPED: begin
          state_d = ASC_STOPPED;
        end
        ASC_ARMED: begin
          if (trig_edge) begin
            state_d = ASC_RUNNING;
            ch_d    = first_channel(mode_q);
          end
        end
        ASC_RUNNING: begin
          if (hw_q && trig_edge) begin
            // a fresh trigger mid-pass restarts the pass
            abort_d = 1'b1;
            ch_d    = first_channel(mode_q);
          end else if (sar_done) begin
            result_d = sar_result;
            res_ch_d = ch_q;
            irq_d    = hw_q || !sel_q;
            if (sel_q)
              ch_d = last_ch;
            else
              ch_d = next_channel(ch_q, last_ch);
            if (hw_q && (sel_q || ch_q == last_ch))
              state_d = ASC_ARMED;
          end else if (!sar_busy && !start_q && !abort_q) begin
            start_d = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_q  <= ASC_STOPPED;
      mode_q   <= MODE_RESET;
      ch_q     <= CH_RESET;
      res_ch_q <= CH_RESET;
      result_q <= RESULT_RESET;
      start_q  <= 1'b0;
      abort_q  <= 1'b0;
      irq_q    <= 1'b0;
    end else if (enable_i) begin
      state_q  <= state_d;
      mode_q   <= mode_d;
      ch_q     <= ch_d;
      res_ch_q <= res_ch_d;
      result_q <= result_d;
      start_q  <= start_d;
      abort_q  <= abort_d;
      irq_q    <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign analog_input_n_sel_o    = ch_q;
  assign converter_mode_reg_o    = mode_q;
  assign conversion_result_reg_o = result_q;
  assign result_channel_o        = res_ch_q;
  assign busy_o                  = sar_busy;
  // single-cycle pulse, fit for a transfer engine as well as a vector
  assign conversion_done_irq_o   = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_mux_held;
    @(posedge clock_i iff enable_i) disable iff (reset_i)
      sar_busy && !abort_q && !mode_wr_i && !trig_edge |=> $stable(ch_q);
  endproperty
  a_mux_held: assert property (p_mux_held) else $error("mux moved mid conversion");

  property p_result_hold;
    @(posedge clock_i iff enable_i) disable iff (reset_i)
      !sar_done |=> $stable(result_q);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed unbidden");

  property p_armed_wait;
    @(posedge clock_i iff enable_i) disable iff (reset_i)
      state_q == ASC_ARMED && !trig_edge && !mode_wr_i |=> state_q == ASC_ARMED && !start_q;
  endproperty
  a_armed_wait: assert property (p_armed_wait) else $error("started without trigger");

  sequence s_sw_go;
    mode_wr_i && mode_wdata_i[MODE_RUN_BIT] && !mode_wdata_i[MODE_HW_BIT];
  endsequence

  property p_sw_start;
    @(posedge clock_i iff enable_i) disable iff (reset_i)
      s_sw_go ##1 !mode_wr_i ##1 !mode_wr_i |=> start_q;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start ignored");

  property p_scan_step;
    @(posedge clock_i iff enable_i) disable iff (reset_i)
      state_q == ASC_RUNNING && !sel_q && sar_done && !mode_wr_i && !trig_edge
        && ch_q != last_ch |=> ch_q == $past(ch_q) + 3'h1;
  endproperty
  a_scan_step: assert property (p_scan_step) else $error("scan did not advance");

  property p_sel_fixed;
    @(posedge clock_i iff enable_i) disable iff (reset_i)
      sel_q && state_q != ASC_STOPPED |-> ch_q == last_ch;
  endproperty
  a_sel_fixed: assert property (p_sel_fixed) else $error("select input moved");

  sequence s_halted;
    state_q == ASC_STOPPED ##1 !sar_busy [*3];
  endsequence

  property p_stop;
    @(posedge clock_i iff enable_i) disable iff (reset_i)
      mode_wr_i && !mode_wdata_i[MODE_RUN_BIT] |=> s_halted;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not halt conversion");

  property p_irq_mode;
    @(posedge clock_i iff enable_i) disable iff (reset_i)
      conversion_done_irq_o |-> hw_q || !sel_q;
  endproperty
  a_irq_mode: assert property (p_irq_mode) else $error("request in software select");

  property p_irq_on_result;
    @(posedge clock_i iff enable_i) disable iff (reset_i)
      sar_done && state_q == ASC_RUNNING && !mode_wr_i && !(hw_q && trig_edge)
        && (hw_q || !sel_q) |=> conversion_done_irq_o && result_q == $past(sar_result);
  endproperty
  a_irq_on_result: assert property (p_irq_on_result) else $error("missing request");

  property p_irq_pulse;
    @(posedge clock_i iff enable_i) disable iff (reset_i)
      conversion_done_irq_o |=> !conversion_done_irq_o;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("request longer than a cycle");

  ////////////////////////////////////////////////////////////////////////////
  // result hand-over, one step per completed conversion
  sequence s_done_taken;
    sar_done && state_q == ASC_RUNNING && !mode_wr_i && !(hw_q && trig_edge);
  endsequence

  property p_result_channel;
    @(posedge clock_i iff enable_i) disable iff (reset_i)
      s_done_taken |=> result_channel_o == $past(ch_q);
  endproperty
  a_result_channel: assert property (p_result_channel) else $error("result input wrong");

  property p_sel_silent;
    @(posedge clock_i iff enable_i) disable iff (reset_i)
      s_done_taken ##0 (!hw_q && sel_q) |=> !conversion_done_irq_o
        && result_q == $past(sar_result);
  endproperty
  a_sel_silent: assert property (p_sel_silent) else $error("select result wrong");

  property p_hw_rearm;
    @(posedge clock_i iff enable_i) disable iff (reset_i)
      s_done_taken ##0 (hw_q && (sel_q || ch_q == last_ch)) |=> state_q == ASC_ARMED;
  endproperty
  a_hw_rearm: assert property (p_hw_rearm) else $error("pass did not re-arm");

  // software modes run on without a new start bit
  property p_sw_restart;
    @(posedge clock_i iff enable_i) disable iff (reset_i)
      s_done_taken ##0 !hw_q ##1 !mode_wr_i |=> start_q;
  endproperty
  a_sw_restart: assert property (p_sw_restart) else $error("select did not run on");

  property p_start_takes;
    @(posedge clock_i iff enable_i) disable iff (reset_i)
      start_q |=> sar_busy;
  endproperty
  a_start_takes: assert property (p_start_takes) else $error("start not taken");

  property p_stopped_quiet;
    @(posedge clock_i iff enable_i) disable iff (reset_i)
      state_q == ASC_STOPPED |-> !conversion_done_irq_o && !start_q;
  endproperty
  a_stopped_quiet: assert property (p_stopped_quiet) else $error("activity while stopped");

  property p_reset;
    @(posedge clock_i)
      reset_i |=> state_q == ASC_STOPPED && mode_q == MODE_RESET && !conversion_done_irq_o;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

endmodule

// *** asc_pkg.sv ***
/*
  asc_pkg: constants, types and helper functions of the converter sequencer.
  Assumes a 40 ns system clock; all cycle counts are derived from it here.
*/
package asc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int CONV_TIME_NS  = 30000;
  localparam int CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
  // one sample step, then one step per result bit
  localparam int SAR_STEPS     = 9;
  // rounds down: the figure is approximate, shorter is the safe side
  localparam int STEP_CYCLES   = CONV_CYCLES / SAR_STEPS;
  localparam int STEP_CNT_W    = 8;
  localparam int CONV_CNT_W    = 10;

  ////////////////////////////////////////////////////////////////////////////
  // converter mode register layout
  localparam int MODE_W       = 8;
  localparam int MODE_RUN_BIT = 7;
  localparam int MODE_HW_BIT  = 6;
  localparam int MODE_SEL_BIT = 5;
  localparam int MODE_CH_LSB  = 0;
  localparam int CH_W         = 3;
  localparam int RES_W        = 8;
  localparam logic [MODE_W-1:0] MODE_RESET   = 8'h00;
  localparam logic [RES_W-1:0]  RESULT_RESET = 8'h00;
  localparam logic [CH_W-1:0]   CH_RESET     = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // states
  typedef enum {ASC_STOPPED, ASC_ARMED, ASC_RUNNING} asc_state_e;
  typedef enum {SAR_IDLE, SAR_SAMPLE, SAR_BITS} asc_sar_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // channel helpers
  function automatic logic [CH_W-1:0] mode_channel(input logic [MODE_W-1:0] mode);
    mode_channel = mode[MODE_CH_LSB +: CH_W];
  endfunction

  // scan always begins at input 0; select sits on the programmed input
  function automatic logic [CH_W-1:0] first_channel(input logic [MODE_W-1:0] mode);
    first_channel = mode[MODE_SEL_BIT] ? mode_channel(mode) : CH_RESET;
  endfunction

  function automatic logic [CH_W-1:0] next_channel(input logic [CH_W-1:0] ch,
                                                   input logic [CH_W-1:0] last);
    next_channel = (ch == last) ? CH_RESET : ch + 3'h1;
  endfunction

endpackage

// *** asc_edge_sync.sv ***
/*
  asc_edge_sync: three-stage synchroniser and rising-edge detector for a pin.
  Assumes the pin is asynchronous to clock_i; the edge pulse is one cycle.
*/
`timescale 1ns/1ns
module asc_edge_sync
  import asc_pkg::*;
(
  // clock and reset
  input  wire logic clock_i,
  input  wire logic reset_i,
  input  wire logic enable_i,
  // pin and event
  input  wire logic pin_i,
  output logic      edge_o
);

  logic s1_q, s2_q, s3_q, level_q, edge_q;
  logic level_d, edge_d;

  ////////////////////////////////////////////////////////////////////////////
  // a change counts only once stages two and three agree
  always_comb begin
    level_d = (s2_q == s3_q) ? s3_q : level_q;
    edge_d  = level_d & ~level_q;
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
      edge_q  <= 1'b0;
    end else if (enable_i) begin
      s1_q    <= pin_i;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
      edge_q  <= edge_d;
    end
  end

  assign edge_o = edge_q;

  ////////////////////////////////////////////////////////////////////////////
  property p_edge_once;
    @(posedge clock_i iff enable_i) disable iff (reset_i)
      edge_o |-> level_q && !$past(level_q, 2) ##1 !edge_o;
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("trigger edge not a single rise");

endmodule

// *** asc_sar_core.sv ***
/*
  asc_sar_core: successive-approximation step engine, one bit per step.
  Assumes the comparator output is on clock_i's domain and settled by each
  step's end; abort wins over start.
*/
`timescale 1ns/1ns
module asc_sar_core
  import asc_pkg::*;
#(
  parameter int W        = RES_W,
  parameter int STEP_CYC = STEP_CYCLES
)(
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  input  wire logic         enable_i,
  // control
  input  wire logic         start_i,
  input  wire logic         abort_i,
  input  wire logic         comparator_i,
  // status and data
  output logic              sample_o,
  output logic              busy_o,
  output logic              done_o,
  output logic [W-1:0]      trial_o,
  output logic [W-1:0]      result_o
);

  localparam int BIT_W = $clog2(W);

  asc_sar_state_e          state_q, state_d;
  logic [STEP_CNT_W-1:0]   step_q, step_d;
  logic [BIT_W-1:0]        bit_q, bit_d;
  logic [W-1:0]            trial_q, trial_d, result_q, result_d;
  logic                    done_q, done_d;
  logic                    step_end;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d  = state_q;
    step_d   = step_q;
    bit_d    = bit_q;
    trial_d  = trial_q;
    result_d = result_q;
    done_d   = 1'b0;
    step_end = (step_q == STEP_CNT_W'(STEP_CYC - 1));
    unique case (state_q)
      SAR_IDLE: begin
        if (start_i) begin
          state_d = SAR_SAMPLE;
          step_d  = '0;
          trial_d = '0;
        end
      end
      SAR_SAMPLE: begin
        step_d = step_q + 1'b1;
        if (step_end) begin
          state_d = SAR_BITS;
          step_d  = '0;
          bit_d   = BIT_W'(W - 1);
          trial_d = {1'b1, {(W-1){1'b0}}};
        end
      end
      SAR_BITS: begin
        step_d = step_q + 1'b1;
        if (step_end) begin
          step_d         = '0;
          trial_d[bit_q] = comparator_i;
          if (bit_q == '0) begin
            state_d  = SAR_IDLE;
            done_d   = 1'b1;
            result_d = trial_d;
          end else begin
            bit_d              = bit_q - 1'b1;
            trial_d[bit_q - 1'b1] = 1'b1;
          end
        end
      end
    endcase
    if (abort_i) begin
      state_d = SAR_IDLE;
      done_d  = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_q  <= SAR_IDLE;
      step_q   <= '0;
      bit_q    <= '0;
      trial_q  <= '0;
      result_q <= '0;
      done_q   <= 1'b0;
      sample_o <= 1'b0;
      busy_o   <= 1'b0;
    end else if (enable_i) begin
      state_q  <= state_d;
      step_q   <= step_d;
      bit_q    <= bit_d;
      trial_q  <= trial_d;
      result_q <= result_d;
      done_q   <= done_d;
      sample_o <= (state_d == SAR_SAMPLE);
      busy_o   <= (state_d != SAR_IDLE);
    end
  end

  assign done_o   = done_q;
  assign trial_o  = trial_q;
  assign result_o = result_q;

  ////////////////////////////////////////////////////////////////////////////
  // helper: cycles spent converting, for the timing check
  logic [CONV_CNT_W-1:0] cyc_q;
  // reset clears it on any edge; otherwise it moves only on enabled edges, so a frozen clock leaves it alone too
  always_ff @(posedge clock_i) begin
    if (reset_i)
      cyc_q <= '0;
    else if (enable_i)
      cyc_q <= (state_q == SAR_IDLE) ? '0 : cyc_q + 1'b1;
  end

  sequence s_bits_begin;
    $rose(state_q == SAR_BITS);
  endsequence

  property p_msb_first;
    @(posedge clock_i iff enable_i) disable iff (reset_i)
      s_bits_begin |-> trial_q == {1'b1, {(W-1){1'b0}}} && bit_q == BIT_W'(W - 1);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("trial did not open at msb");

  property p_conv_time;
    @(posedge clock_i iff enable_i) disable iff (reset_i)
      done_o |-> cyc_q == CONV_CNT_W'(SAR_STEPS * STEP_CYC) && !busy_o;
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion length wrong");

endmodule

// *** asc_analog_src.sv ***
/*
  asc_analog_src: eight fixed analog levels behind the mux, ideal comparator.
  Assumes mux select and trial code come from flops on the system clock.
*/
`timescale 1ns/1ns
module asc_analog_src
  import asc_pkg::*;
#(
  parameter logic [63:0] LEVELS = 64'hff_de_a1_80_43_24_05_00
)(
  // front end
  input  wire logic [CH_W-1:0]  sel_i,
  input  wire logic [RES_W-1:0] dac_i,
  output logic                  comparator_o
);
  // no noise or settling: a wrong bit is the converter's fault
  always_comb begin
    comparator_o = LEVELS[sel_i*RES_W +: RES_W] >= dac_i;
  end
endmodule

// *** tb.sv ***
/*
  tb: self-checking bench for the converter sequencer, row table then
  hand-written retrigger, lost-write, stop and reset cases.
  Assumes asc_analog_src as the far side and the package step counts.
*/
`timescale 1ns/1ns
module tb
  import asc_pkg::*;
;
  localparam logic [63:0] LEVELS = 64'hff_de_a1_80_43_24_05_00;
  typedef struct {logic [7:0] mode; int n;} asc_row_s;
  logic              clock_i;
  logic              reset_i;
  logic              enable_i;
  logic              mode_wr_i;
  logic [MODE_W-1:0] mode_wdata_i;
  logic              trig;
  logic              comparator_i;
  logic [CH_W-1:0]   sel;
  logic              sample_hold_o;
  logic [RES_W-1:0]  dac_code_o;
  logic [MODE_W-1:0] converter_mode_reg_o;
  logic [RES_W-1:0]  conversion_result_reg_o;
  logic [CH_W-1:0]   result_channel_o;
  logic              busy_o;
  logic              conversion_done_irq_o;
  logic              irq_prev = 1'b0;
  int                failures = 0;
  int                comparisons = 0;
  int                irqs = 0;
  int                ends = 0;
  int                run_len = 0;
  int                last_len = 0;
  int                samp_len = 0;
  int                last_samp = 0;
  // sw scan with spare bits set, sw select 5, full scan, sw select 0, hw scan, hw select
  asc_row_s rows [6] = '{'{8'h9a, 4}, '{8'ha5, 3}, '{8'h87, 9}, '{8'ha0, 2},
                         '{8'hc1, 2}, '{8'he3, 1}};

  asc_sequencer_control uut (
    .clock_i                (clock_i),
    .reset_i                (reset_i),
    .enable_i               (enable_i),
    .mode_wr_i              (mode_wr_i),
    .mode_wdata_i           (mode_wdata_i),
    .external_trigger_irq_i (trig),
    .comparator_i           (comparator_i),
    .analog_input_n_sel_o   (sel),
    .sample_hold_o          (sample_hold_o),
    .dac_code_o             (dac_code_o),
    .converter_mode_reg_o   (converter_mode_reg_o),
    .conversion_result_reg_o(conversion_result_reg_o),
    .result_channel_o       (result_channel_o),
    .busy_o                 (busy_o),
    .conversion_done_irq_o  (conversion_done_irq_o)
  );

  asc_analog_src #(.LEVELS(LEVELS)) src (
    .sel_i       (sel),
    .dac_i       (dac_code_o),
    .comparator_o(comparator_i)
  );

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_num(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      failures++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // busy run lengths and request pulses, seen mid-cycle where they are settled
  always @(negedge clock_i) begin
    irq_prev <= conversion_done_irq_o;
    if (conversion_done_irq_o === 1'b1) begin
      irqs <= irqs + 1;
      check_val("irq_width", 8'h00, 8'(irq_prev));
    end
    if (sample_hold_o === 1'b1) begin
      samp_len <= samp_len + 1;
    end
    if (busy_o === 1'b1) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      last_len <= run_len;
      last_samp <= samp_len;
      samp_len <= 0;
      ends <= ends + 1;
      run_len <= 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic write_mode(input logic [7:0] v);
    mode_wr_i = 1'b1;
    mode_wdata_i = v;
    @(negedge clock_i);
    mode_wr_i = 1'b0;
    // margin lets an aborted conversion's end land before snapshots
    repeat (4) @(negedge clock_i);
    check_val("mode", v, converter_mode_reg_o);
  endtask

  task automatic check_conv(input logic [2:0] ch, input logic irq_exp);
    int e0;
    int i0;
    e0 = ends;
    i0 = irqs;
    for (int k = 0; k < 3000 && ends == e0; k++) @(negedge clock_i);
    if (ends == e0) begin
      failures++;
      tally_and_finish();
    end
    repeat (3) @(negedge clock_i);
    check_val("result", LEVELS[ch*8 +: 8], conversion_result_reg_o);
    check_val("channel", 8'(ch), 8'(result_channel_o));
    check_num("irqs", int'(irq_exp), irqs - i0);
    check_num("conv_cycles", SAR_STEPS * STEP_CYCLES, last_len);
    check_num("sample_cycles", STEP_CYCLES, last_samp);
  endtask

  task automatic quiet(input string what, input int n);
    int b;
    int i0;
    b = 0;
    i0 = irqs;
    repeat (n) begin
      @(negedge clock_i);
      if (busy_o !== 1'b0) b++;
    end
    check_num(what, 0, b + irqs - i0);
  endtask

  task automatic check_reset();
    check_val("mode_rst", MODE_RESET, converter_mode_reg_o);
    check_val("result_rst", RESULT_RESET, conversion_result_reg_o);
    check_val("flags_rst", 8'h00, 8'({busy_o, conversion_done_irq_o, sample_hold_o}));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [2:0] ch;
    reset_i = 1'b1;
    enable_i = 1'b1;
    mode_wr_i = 1'b0;
    mode_wdata_i = 8'h00;
    trig = 1'b0;
    repeat (16) @(negedge clock_i);
    check_reset();
    reset_i = 1'b0;
    quiet("idle_after_reset", 100);
    foreach (rows[r]) begin
      write_mode(rows[r].mode);
      if (rows[r].mode[6]) begin
        quiet("armed_idle", 200);
        trig = 1'b1;
      end
      ch = rows[r].mode[5] ? rows[r].mode[2:0] : 3'h0;
      for (int i = 0; i < rows[r].n; i++) begin
        check_conv(ch, rows[r].mode[6] | ~rows[r].mode[5]);
        if (!rows[r].mode[5]) ch = (ch == rows[r].mode[2:0]) ? 3'h0 : ch + 3'h1;
      end
      if (rows[r].mode[6]) begin
        // pin still high: a level must not start another pass
        quiet("level_no_restart", 1000);
        trig = 1'b0;
      end
    end
    // a fresh trigger mid-pass restarts the scan at its first input
    write_mode(8'hc2);
    trig = 1'b1;
    repeat (900) @(negedge clock_i);
    trig = 1'b0;
    repeat (8) @(negedge clock_i);
    trig = 1'b1;
    repeat (20) @(negedge clock_i);
    for (int i = 0; i < 3; i++) check_conv(3'(i), 1'b1);
    trig = 1'b0;
    // write with clock enable low is lost
    write_mode(8'h83);
    check_conv(3'h0, 1'b1);
    check_conv(3'h1, 1'b1);
    repeat (100) @(negedge clock_i);
    enable_i = 1'b0;
    mode_wr_i = 1'b1;
    mode_wdata_i = 8'h00;
    @(negedge clock_i);
    mode_wr_i = 1'b0;
    enable_i = 1'b1;
    @(negedge clock_i);
    check_val("lost_write", 8'h83, converter_mode_reg_o);
    write_mode(8'h03);
    quiet("stopped", 1000);
    check_val("result_held", LEVELS[15:8], conversion_result_reg_o);
    // reset in mid-conversion
    write_mode(8'h82);
    repeat (300) @(negedge clock_i);
    reset_i = 1'b1;
    repeat (16) @(negedge clock_i);
    check_reset();
    reset_i = 1'b0;
    quiet("idle_after_reset", 1000);
    tally_and_finish();
  end
endmodule
